// ==== dv/ppc_monitor.sv ====
`timescale 1ns/100ps
`include "ppc_map.vh"
module ppc_monitor
(
  input wire        clk,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire [7:0]  prnData,
  input wire        prnStrobe,
  input wire        prnBusyIn,
  input wire        auxOutFirst,
  input wire        auxOutSecond,
  input wire        irq
);
  localparam int STB_CYC = `PPC_STROBE_NS * `PPC_CLK_MHZ / 1000;
  reg [7:0] stbCnt_reg;
  wire auxWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
               wb_adr_i == `PPC_CMD_OFF && wb_sel_i[1] &&
               wb_sel_i[0] && wb_dat_i[10] && !wb_dat_i[11];
  always @(posedge clk)
    stbCnt_reg <= (rst || !prnStrobe) ? 8'h00 : stbCnt_reg + 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////
  AST_IRQ_IDLE: assert property (prnStrobe |-> !irq)
    else $error("irq while printing");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_STB_LEN: assert property ($fell(prnStrobe) |-> stbCnt_reg == STB_CYC)
    else $error("strobe width");
  AST_DATA_STABLE: assert property (prnStrobe && $past(prnStrobe)
    |-> $stable(prnData)) else $error("data moved");
  AST_AUX_FIRST: assert property (auxWr |=>
    auxOutFirst == $past(wb_dat_i[1])) else $error("aux first");
  AST_AUX_SECOND: assert property (auxWr |=>
    auxOutSecond == $past(wb_dat_i[0])) else $error("aux second");
  // Busy held three cycles must block a new strobe
  AST_BUSY_HOLD: assert property ($rose(prnStrobe) |->
    !($past(prnBusyIn) && $past(prnBusyIn, 2) && $past(prnBusyIn, 3)))
    else $error("strobe while busy");
endmodule // ppc_monitor
bind ppc_printer_port ppc_monitor u_mon (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .prnData, .prnStrobe, .prnBusyIn, .auxOutFirst, .auxOutSecond, .irq);

// ==== dv/ppc_printer_model.sv ====
`timescale 1ns/100ps
module ppc_printer_model
(
  input  wire       clk,
  input  wire [7:0] prnData,
  input  wire       prnStrobe,
  input  wire       auxOutFirst,
  input  wire       auxOutSecond,
  input  wire       stall,
  input  wire       plug,
  output wire       hwAcknowledgeIn,
  output wire       prnBusyIn
);
  reg       stbQ_reg = 1'h0;
  reg       ack_reg = 1'h0;
  reg [2:0] cnt_reg = 3'h0;
  reg [7:0] lastChar = 8'h00;
  integer   nChars = 0;
  // Ack drops at each strobe so a stale ack never releases the port
  always @(posedge clk)
  begin
    if (prnStrobe && !stbQ_reg)
    begin
      nChars <= nChars + 1;
      lastChar <= prnData;
      ack_reg <= 1'h0;
      cnt_reg <= 3'h0;
    end
    else if (!prnStrobe && !ack_reg && !stall)
    begin
      cnt_reg <= cnt_reg + 3'h1;
      ack_reg <= cnt_reg == 3'h3;
    end
    stbQ_reg <= prnStrobe;
  end
  // Plug loops each aux line back inverted
  assign hwAcknowledgeIn = plug ? ~auxOutFirst : ack_reg;
  assign prnBusyIn = plug ? ~auxOutSecond : stall;
endmodule // ppc_printer_model

// ==== dv/ppc_tb.sv ====
`timescale 1ns/100ps
`include "ppc_map.vh"
module tb;
  reg         clk, rst, cyc, stb, we, stall, plug;
  reg  [11:0] adr;
  reg  [31:0] datI, q;
  wire [31:0] datO;
  wire [7:0]  pData;
  wire        ack, irq, strb, ackIn, busyIn, aux1, aux2;
  integer     n_errors, n_checks, i;
  ppc_printer_port u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .prnData(pData),
    .prnStrobe(strb), .hwAcknowledgeIn(ackIn), .prnBusyIn(busyIn),
    .prnNotReadyIn(1'h0), .prnSelectIn(1'h0), .auxOutFirst(aux1),
    .auxOutSecond(aux2), .irq(irq));
  ppc_printer_model u_prn (.clk(clk), .prnData(pData), .prnStrobe(strb),
    .auxOutFirst(aux1), .auxOutSecond(aux2), .stall(stall), .plug(plug),
    .hwAcknowledgeIn(ackIn), .prnBusyIn(busyIn));
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task complete_run;
  begin
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer k;
  begin
    k = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    datI <= d;
    @(posedge clk);
    while (ack !== 1'h1 && k < 20)
    begin
      @(posedge clk);
      k = k + 1;
    end
    q = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (k >= 20)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end
  endtask
  // Polls status until not busy; a hang is cut short here
  task wait_idle;
    integer k;
  begin
    k = 0;
    q = 32'h0;
    while (q[7] !== 1'h1 && k < 600)
    begin
      xfer(1'h0, `PPC_STATUS_OFF, 32'h0);
      k = k + 1;
    end
    if (k >= 600)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, cyc, stb, we, stall, plug, adr, datI, n_errors, n_checks} = 0;
    rst = 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    xfer(1'h0, `PPC_STATUS_OFF, 32'h0);
    chk(q & 32'hC0, 32'hC0);
    xfer(1'h1, `PPC_INT_CTRL_OFF, 32'h3);
    @(posedge clk);
    chk(irq, 1'h1);
    for (i = 0; i < 4; i = i + 1)
      xfer(1'h1, `PPC_BUF_BASE + 4 * i, 32'h41 + i);
    xfer(1'h1, `PPC_START_OFF, 32'h0);
    xfer(1'h1, `PPC_TERM_ADDR_OFF, 32'h8004);
    stall <= 1'h1;
    xfer(1'h1, `PPC_CMD_OFF, 32'h100);
    @(posedge clk);
    chk(irq, 1'h0);
    repeat (200) @(posedge clk);
    xfer(1'h0, `PPC_CURRENT_OFF, 32'h0);
    chk(q & 32'hFFFF, 32'h0);
    stall <= 1'h0;
    wait_idle;
    xfer(1'h0, `PPC_CURRENT_OFF, 32'h0);
    chk(q & 32'hFFFF, 32'h4);
    chk(u_prn.lastChar, 8'h44);
    chk(irq, 1'h1);
    xfer(1'h1, `PPC_CMD_OFF, 32'h200);
    wait_idle;
    chk(u_prn.nChars, 8);
    $display("print tests done");
    xfer(1'h1, `PPC_BUF_BASE + 4, `PPC_CHAR_DC3);
    xfer(1'h1, `PPC_CMD_OFF, 32'h100);
    repeat (300) @(posedge clk);
    xfer(1'h0, `PPC_STATUS_OFF, 32'h0);
    chk(q & 32'hC0, 32'h0);
    xfer(1'h1, `PPC_START_OFF, 32'h3);
    xfer(1'h1, `PPC_CMD_OFF, 32'h100);
    xfer(1'h0, `PPC_CURRENT_OFF, 32'h0);
    chk(q & 32'hFFFF, 32'h3);
    xfer(1'h1, `PPC_BUF_BASE + 12, `PPC_CHAR_DC1);
    xfer(1'h1, `PPC_CMD_OFF, 32'h100);
    wait_idle;
    chk(q & 32'hC0, 32'hC0);
    $display("select tests done");
    plug <= 1'h1;
    for (i = 0; i < 4; i = i + 1)
    begin
      xfer(1'h1, `PPC_CMD_OFF, 32'h400 + i);
      xfer(1'h0, `PPC_STATUS_OFF, 32'h0);
      chk(q[5:4], {i[0], i[1]});
      chk(q[3:2], {~i[0], ~i[1]});
    end
    plug <= 1'h0;
    xfer(1'h0, 12'h0F0, 32'h0);
    chk(q, 32'h0);
    $display("aux tests done");
    complete_run;
  end
endmodule // tb

// ==== include/ppc_map.vh ====
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
// Register byte offsets
`define PPC_CMD_OFF       12'h000
`define PPC_STATUS_OFF    12'h004
`define PPC_START_OFF     12'h008
`define PPC_CURRENT_OFF   12'h00C
`define PPC_TERM_ADDR_OFF 12'h010
`define PPC_TERM_CHAR_OFF 12'h014
`define PPC_INT_CTRL_OFF  12'h018
// Character buffer window: 256 words from here
`define PPC_BUF_BASE      12'h400
// Command register fields
`define PPC_CMD_AUX_SECOND 0
`define PPC_CMD_AUX_FIRST  1
`define PPC_CMD_PRINT      8
`define PPC_CMD_ALT_PRINT  9
`define PPC_CMD_AUX        10
`define PPC_CMD_CLEAR      11
// Status byte fields
`define PPC_ST_NOT_READY   1
`define PPC_ST_ACK_IN      2
`define PPC_ST_BUSY_IN     3
`define PPC_ST_AUX_FIRST   4
`define PPC_ST_AUX_SECOND  5
`define PPC_ST_SELECTED    6
`define PPC_ST_NOT_BUSY    7
// Terminating address field: high means stop on address
`define PPC_TERM_ADDR_MODE 15
// Interrupt control fields
`define PPC_INT_MASK       0
`define PPC_INT_MASTER     1
// Control characters
`define PPC_CHAR_DC1       8'h11
`define PPC_CHAR_DC3       8'h13
// Reset values
`define PPC_START_RST      16'h0000
`define PPC_TERM_ADDR_RST  16'h8000
`define PPC_TERM_CHAR_RST  8'h00
// Strobe timing
`define PPC_STROBE_NS      1000
`define PPC_CLK_MHZ        40
`endif

// ==== verilog/ppc_char_mem.v ====
`timescale 1ns/100ps
module ppc_char_mem
(
  input  wire       clk,
  input  wire       wrEn,
  input  wire [7:0] wrAddr,
  input  wire [7:0] wrData,
  input  wire [7:0] rdAddr,
  output reg  [7:0] rdData
);
  reg [7:0] mem [0:255];

  always @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // ppc_char_mem

// ==== verilog/ppc_printer_port.v ====
// Functional notes
// - Interrupt when mask, master enable, not-busy
// - No interrupt while not-busy is low
// - Mid-line de-select character clears selected flag
// - After de-select, stay busy and stalled
// - New print start aborts, reloads current address
// - Select character first to de-selected printer selects
// - Aux command bit 1 drives first line
// - Aux command bit 0 drives second line
// - First line loops back inverted onto acknowledge
// - Second line loops back inverted onto busy
// - Alternate print start equals primary print start
`timescale 1ns/100ps
`include "ppc_map.vh"
module ppc_printer_port
(
  input  wire        clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire [7:0]  prnData,
  output wire        prnStrobe,
  input  wire        hwAcknowledgeIn,
  input  wire        prnBusyIn,
  input  wire        prnNotReadyIn,
  input  wire        prnSelectIn,
  output reg         auxOutFirst,
  output reg         auxOutSecond,
  output wire        irq
);
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_READ   = 3'd1;
  localparam [2:0] ST_CHECK  = 3'd2;
  localparam [2:0] ST_STROBE = 3'd3;
  localparam [2:0] ST_WAIT   = 3'd4;
  localparam [2:0] ST_STALL  = 3'd5;

  reg  [2:0]  state_reg;
  reg  [15:0] startAddr_reg;
  reg  [15:0] currentAddr_reg;
  reg  [15:0] termAddr_reg;
  reg  [7:0]  termChar_reg;
  reg  [1:0]  intCtrl_reg;
  reg         selected_reg;
  reg         dc3Sent_reg;
  reg         selPrev_reg;
  reg  [7:0]  data_reg;
  reg         strobeStart;
  wire        strobeDone;
  wire [7:0]  memData;
  wire        notBusy;
  wire [7:0]  statusByte;
  wire        wbReq;
  wire        wbWr;
  wire        cmdWr;
  wire        startCmd;
  wire        clearCmd;
  wire        bufWr;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr  = wbReq & wb_we_i;
  assign cmdWr = wbWr & (wb_adr_i == `PPC_CMD_OFF) & wb_sel_i[1];
  assign startCmd = cmdWr & (wb_dat_i[`PPC_CMD_PRINT]
                    | wb_dat_i[`PPC_CMD_ALT_PRINT]);
  assign clearCmd = cmdWr & wb_dat_i[`PPC_CMD_CLEAR];
  assign bufWr = wbWr & wb_sel_i[0] & (wb_adr_i[11:10] == 2'b01);

  assign notBusy = (state_reg == ST_IDLE);
  // Loopback plug shows up only through these input bits
  assign statusByte = {notBusy, selected_reg, auxOutSecond, auxOutFirst,
                       prnBusyIn, hwAcknowledgeIn,
                       prnNotReadyIn, 1'b0};

  assign irq = intCtrl_reg[`PPC_INT_MASK] & intCtrl_reg[`PPC_INT_MASTER]
               & notBusy;

  ////////////////////////////////////////////////////////////////////
  // Register file
  always @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
      startAddr_reg <= `PPC_START_RST;
      termAddr_reg  <= `PPC_TERM_ADDR_RST;
      termChar_reg  <= `PPC_TERM_CHAR_RST;
      intCtrl_reg   <= 2'b00;
      auxOutFirst   <= 1'b0;
      auxOutSecond  <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      if (wbReq & ~wb_we_i)
      begin
        case (wb_adr_i)
          `PPC_STATUS_OFF:    wb_dat_o <= {24'h000000, statusByte};
          `PPC_START_OFF:     wb_dat_o <= {16'h0000, startAddr_reg};
          `PPC_CURRENT_OFF:   wb_dat_o <= {16'h0000, currentAddr_reg};
          `PPC_TERM_ADDR_OFF: wb_dat_o <= {16'h0000, termAddr_reg};
          `PPC_TERM_CHAR_OFF: wb_dat_o <= {24'h000000, termChar_reg};
          `PPC_INT_CTRL_OFF:  wb_dat_o <= {30'h0, intCtrl_reg};
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (wbWr)
      begin
        case (wb_adr_i)
          `PPC_CMD_OFF:
          begin
            if (wb_sel_i[1] & wb_dat_i[`PPC_CMD_AUX])
            begin
              auxOutFirst  <= wb_dat_i[`PPC_CMD_AUX_FIRST];
              auxOutSecond <= wb_dat_i[`PPC_CMD_AUX_SECOND];
            end
          end
          `PPC_START_OFF:
          begin
            if (wb_sel_i[0])
              startAddr_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              startAddr_reg[15:8] <= wb_dat_i[15:8];
          end
          `PPC_TERM_ADDR_OFF:
          begin
            if (wb_sel_i[0])
              termAddr_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              termAddr_reg[15:8] <= wb_dat_i[15:8];
          end
          `PPC_TERM_CHAR_OFF:
          begin
            if (wb_sel_i[0])
              termChar_reg <= wb_dat_i[7:0];
          end
          `PPC_INT_CTRL_OFF:
          begin
            if (wb_sel_i[0])
              intCtrl_reg <= wb_dat_i[1:0];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Character streamer
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg       <= ST_IDLE;
      currentAddr_reg <= `PPC_START_RST;
      selected_reg    <= 1'b1;
      dc3Sent_reg     <= 1'b0;
      selPrev_reg     <= 1'b0;
      data_reg        <= 8'h00;
      strobeStart     <= 1'b0;
    end
    else
    begin
      strobeStart <= 1'b0;
      selPrev_reg <= prnSelectIn;
      // De-select after DC3 wins over a pushbutton select in the same cycle
      if (prnSelectIn & ~selPrev_reg)
        selected_reg <= 1'b1;
      if (clearCmd)
      begin
        state_reg   <= ST_IDLE;
        dc3Sent_reg <= 1'b0;
      end
      else if (startCmd)
      begin
        currentAddr_reg <= startAddr_reg;
        dc3Sent_reg     <= 1'b0;
        state_reg       <= ST_READ;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
          end
          ST_READ:
          begin
            if (termAddr_reg[`PPC_TERM_ADDR_MODE] &
                (currentAddr_reg[14:0] == termAddr_reg[14:0]))
              state_reg <= ST_IDLE;
            else
              state_reg <= ST_CHECK;
          end
          ST_CHECK:
          begin
            if (~termAddr_reg[`PPC_TERM_ADDR_MODE] &
                (memData == termChar_reg))
              state_reg <= ST_IDLE;
            else if (~selected_reg & (memData != `PPC_CHAR_DC1))
              state_reg <= ST_STALL;
            else if (~prnBusyIn)
            begin
              data_reg    <= memData;
              strobeStart <= 1'b1;
              state_reg   <= ST_STROBE;
              if (memData == `PPC_CHAR_DC1)
                selected_reg <= 1'b1;
              dc3Sent_reg <= (memData == `PPC_CHAR_DC3);
            end
          end
          ST_STROBE:
          begin
            if (strobeDone)
              state_reg <= ST_WAIT;
          end
          ST_WAIT:
          begin
            // Next character held off until acknowledged
            if (hwAcknowledgeIn)
            begin
              currentAddr_reg <= currentAddr_reg + 16'h0001;
              if (dc3Sent_reg)
              begin
                selected_reg <= 1'b0;
                state_reg    <= ST_STALL;
              end
              else
                state_reg <= ST_READ;
            end
          end
          ST_STALL:
          begin
            // Left only by a new start or a device clear
            state_reg <= ST_STALL;
          end
          default:
          begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign prnData = data_reg;

  ////////////////////////////////////////////////////////////////////
  // Buffer and strobe
  ppc_char_mem u_mem
  (
    .clk    (clk),
    .wrEn   (bufWr),
    .wrAddr (wb_adr_i[9:2]),
    .wrData (wb_dat_i[7:0]),
    .rdAddr (currentAddr_reg[7:0]),
    .rdData (memData)
  );

  ppc_strobe_gen u_strobe
  (
    .clk    (clk),
    .rst    (rst),
    .start  (strobeStart),
    .strobe (prnStrobe),
    .done   (strobeDone)
  );
endmodule // ppc_printer_port

// ==== verilog/ppc_strobe_gen.v ====
`timescale 1ns/100ps
`include "ppc_map.vh"
module ppc_strobe_gen
(
  input  wire clk,
  input  wire rst,
  input  wire start,
  output reg  strobe,
  output reg  done
);
  // Least time, rounded up to whole cycles
  localparam integer STROBE_CYC =
    (`PPC_STROBE_NS * `PPC_CLK_MHZ + 999) / 1000;
  localparam [7:0] LAST = STROBE_CYC[7:0] - 8'h01;

  reg [7:0] count_reg;

  always @(posedge clk)
  begin
    if (rst)
    begin
      strobe    <= 1'b0;
      done      <= 1'b0;
      count_reg <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        strobe    <= 1'b1;
        count_reg <= 8'h00;
      end
      else if (strobe)
      begin
        if (count_reg == LAST)
        begin
          strobe <= 1'b0;
          done   <= 1'b1;
        end
        else
        begin
          count_reg <= count_reg + 8'h01;
        end
      end
    end
  end
endmodule // ppc_strobe_gen
